// File: rtl/hw_divider.sv
// Module: memory-mapped 32 by 16 restoring hardware divider with register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module hw_divider
	import hw_divider_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [8:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	// Interrupt
	output logic            irq
);

	// ****************************************************************
	// Register request
	// ****************************************************************
	reg_req_t req;
	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [31:0]      dividend_r, dividend_nxt;
	logic [15:0]      divisor_r, divisor_nxt;
	logic [31:0]      quotient_r, quotient_nxt;
	logic             enable_r, enable_nxt;
	logic             done_r, done_nxt;
	logic             clkSel_r, clkSel_nxt;
	logic [IRQ_W-1:0] irqStat_r, irqStat_nxt;
	logic [IRQ_W-1:0] irqEn_r, irqEn_nxt;
	logic [7:0]       rdata_r, rdata_nxt;

	// ****************************************************************
	// Division engine
	// ****************************************************************
	div_state_t  state_r, state_nxt;
	logic [1:0]  presc_r, presc_nxt;
	logic [4:0]  step_r, step_nxt;
	logic [16:0] rem_r, rem_nxt;
	logic [31:0] work_r, work_nxt;
	logic        tick;
	logic        startReq;
	logic        finish;
	logic        divZero;
	logic [16:0] remShift;
	logic [16:0] remSub;

	// Start on a write that sets the enable bit
	assign startReq = req.wr && (req.addr == ADDR_CTRL)
		&& req.wdata[CTRL_EN_BIT]; // RULE13

	// Engine clock enable: every 2nd or 4th system cycle
	assign tick = (presc_r == (clkSel_r ? PRESC_DIV4_LAST : PRESC_DIV2_LAST)); // RULE8

	assign divZero  = (divisor_r == 16'h0000);
	assign remShift = {rem_r[15:0], work_r[31]};
	assign remSub   = remShift - {1'b0, divisor_r};
	assign finish   = (state_r == ST_RUN) && tick && (divZero || step_r == STEPS_LAST);

	always_comb
	begin
		state_nxt = state_r;
		presc_nxt = presc_r;
		step_nxt  = step_r;
		rem_nxt   = rem_r;
		work_nxt  = work_r;
		case (state_r)
			ST_IDLE:
			begin
				if (startReq)
				begin
					state_nxt = ST_RUN;
					presc_nxt = 2'h0;
					step_nxt  = 5'h00;
					rem_nxt   = 17'h00000;
					work_nxt  = dividend_r;
				end
			end
			ST_RUN:
			begin
				presc_nxt = tick ? 2'h0 : presc_r + 2'h1;
				if (tick)
				begin
					// One restoring step per engine tick
					if (remSub[16])
					begin
						rem_nxt  = remShift;
						work_nxt = {work_r[30:0], 1'b0};
					end
					else
					begin
						rem_nxt  = remSub;
						work_nxt = {work_r[30:0], 1'b1};
					end // RULE1
					step_nxt = step_r + 5'h01;
					if (finish)
						state_nxt = ST_IDLE;
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			presc_r <= 2'h0;
			step_r  <= 5'h00;
			rem_r   <= 17'h00000;
			work_r  <= 32'h00000000;
		end
		else
		begin
			state_r <= state_nxt;
			presc_r <= presc_nxt;
			step_r  <= step_nxt;
			rem_r   <= rem_nxt;
			work_r  <= work_nxt;
		end
	end

	// ****************************************************************
	// Register writes, result latch and flags
	// ****************************************************************
	always_comb
	begin
		dividend_nxt = dividend_r;
		divisor_nxt  = divisor_r;
		quotient_nxt = quotient_r;
		enable_nxt   = enable_r;
		done_nxt     = done_r;
		clkSel_nxt   = clkSel_r;
		irqStat_nxt  = irqStat_r;
		irqEn_nxt    = irqEn_r;
		if (req.wr)
		begin
			if (req.addr == ADDR_BYTE3)
				dividend_nxt[31:24] = req.wdata; // RULE5 RULE10
			else if (req.addr == ADDR_BYTE2)
				dividend_nxt[23:16] = req.wdata; // RULE10
			else if (req.addr == ADDR_BYTE1)
				dividend_nxt[15:8] = req.wdata; // RULE10
			else if (req.addr == ADDR_BYTE0)
				dividend_nxt[7:0] = req.wdata; // RULE10
			else if (req.addr == ADDR_DIVS_HI)
				divisor_nxt[15:8] = req.wdata; // RULE3 RULE11
			else if (req.addr == ADDR_DIVS_LO)
				divisor_nxt[7:0] = req.wdata; // RULE3 RULE11
			else if (req.addr == ADDR_CTRL)
			begin
				enable_nxt = req.wdata[CTRL_EN_BIT]; // RULE9
				clkSel_nxt = req.wdata[CTRL_CLK_BIT]; // RULE8
			end
			else if (req.addr == ADDR_IRQ_ENABLE)
				irqEn_nxt = req.wdata[IRQ_W-1:0];
			else if (req.addr == ADDR_IRQ_CLEAR)
				irqStat_nxt = irqStat_r & ~req.wdata[IRQ_W-1:0];
		end
		// Quotient bytes take no writes; only the engine updates them
		if (state_r == ST_IDLE && startReq)
		begin
			done_nxt = 1'b0; // RULE7 RULE13
			irqStat_nxt[IRQ_START_BIT] = 1'b1;
		end
		if (finish)
		begin
			quotient_nxt = divZero ? QUOT_DIV_ZERO : work_nxt; // RULE4 RULE14
			done_nxt     = 1'b1; // RULE7 RULE13
			irqStat_nxt[IRQ_DONE_BIT] = 1'b1;
			if (divZero)
				irqStat_nxt[IRQ_DIVZ_BIT] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dividend_r <= {4{BYTE_RST}};
			divisor_r  <= {2{BYTE_RST}};
			quotient_r <= {4{BYTE_RST}};
			enable_r   <= 1'b0;
			done_r     <= DONE_RST;
			clkSel_r   <= 1'b0;
			irqStat_r  <= '0;
			irqEn_r    <= '0;
		end
		else
		begin
			dividend_r <= dividend_nxt;
			divisor_r  <= divisor_nxt;
			quotient_r <= quotient_nxt;
			enable_r   <= enable_nxt;
			done_r     <= done_nxt;
			clkSel_r   <= clkSel_nxt;
			irqStat_r  <= irqStat_nxt;
			irqEn_r    <= irqEn_nxt;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (req.rd)
		begin
			if (req.addr == ADDR_BYTE3)
				rdata_nxt = quotient_r[31:24]; // RULE2 RULE5 RULE12
			else if (req.addr == ADDR_BYTE2)
				rdata_nxt = quotient_r[23:16]; // RULE12
			else if (req.addr == ADDR_BYTE1)
				rdata_nxt = quotient_r[15:8]; // RULE12
			else if (req.addr == ADDR_BYTE0)
				rdata_nxt = quotient_r[7:0]; // RULE12
			else if (req.addr == ADDR_DIVS_HI)
				rdata_nxt = divisor_r[15:8]; // RULE3
			else if (req.addr == ADDR_DIVS_LO)
				rdata_nxt = divisor_r[7:0]; // RULE3
			else if (req.addr == ADDR_CTRL)
				rdata_nxt = {enable_r, done_r, 5'h00, clkSel_r}; // RULE9 RULE7
			else if (req.addr == ADDR_IRQ_STATUS)
				rdata_nxt = {5'h00, irqStat_r};
			else if (req.addr == ADDR_IRQ_ENABLE)
				rdata_nxt = {5'h00, irqEn_r};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	assign regRdata = rdata_r;
	assign irq      = |(irqStat_r & irqEn_r);

endmodule : hw_divider
`default_nettype wire

// File: rtl/hw_divider_pkg.sv
// Package: register map, field layout, reset values and types of the hardware divider
// Summary of operation
// [RULE1] Unsigned 32 by 16 divide, quotient only
// [RULE2] Dividend bytes are write-only
// [RULE3] Divisor bytes are readable and writable
// [RULE4] Quotient bytes are read-only, writes ignored
// [RULE5] Dividend and quotient bytes share addresses
// [RULE6] Software waits for completion before reading quotient
// [RULE7] Completion flag low while busy, high otherwise
// [RULE8] Clock select bit 0: divide by 2 or 4
// [RULE9] Control: enable bit 7, flag bit 6
// [RULE10] Dividend byte order MSB at lowest address
// [RULE11] Divisor high byte bits 15..8, low 7..0
// [RULE12] Quotient byte order same as dividend
// [RULE13] Enable starts one division, flag set on latch
// [RULE14] Zero divisor ends with all-ones quotient
package hw_divider_pkg;

	localparam int          ADDR_W           = 9;
	localparam logic [8:0]  ADDR_DIVS_HI     = 9'h187;
	localparam logic [8:0]  ADDR_DIVS_LO     = 9'h188;
	localparam logic [8:0]  ADDR_CTRL        = 9'h189;
	localparam logic [8:0]  ADDR_BYTE3       = 9'h18C;
	localparam logic [8:0]  ADDR_BYTE2       = 9'h18D;
	localparam logic [8:0]  ADDR_BYTE1       = 9'h18E;
	localparam logic [8:0]  ADDR_BYTE0       = 9'h18F;
	localparam logic [8:0]  ADDR_IRQ_STATUS  = 9'h190;
	localparam logic [8:0]  ADDR_IRQ_ENABLE  = 9'h191;
	localparam logic [8:0]  ADDR_IRQ_CLEAR   = 9'h192;

	localparam int          CTRL_EN_BIT      = 7;
	localparam int          CTRL_DONE_BIT    = 6;
	localparam int          CTRL_CLK_BIT     = 0;
	localparam int          IRQ_DONE_BIT     = 0;
	localparam int          IRQ_START_BIT    = 1;
	localparam int          IRQ_DIVZ_BIT     = 2;
	localparam int          IRQ_W            = 3;

	localparam logic [7:0]  BYTE_RST         = 8'h00;
	localparam logic        DONE_RST         = 1'b1;
	localparam logic [4:0]  STEPS_LAST       = 5'h1F;
	localparam logic [1:0]  PRESC_DIV2_LAST  = 2'h1;
	localparam logic [1:0]  PRESC_DIV4_LAST  = 2'h3;
	localparam logic [31:0] QUOT_DIV_ZERO    = 32'hFFFFFFFF;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} div_state_t;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage : hw_divider_pkg

// File: verif/div_asserts.sv
// Checker: register port and interrupt relations of the divider
`timescale 1ns/100ps
`default_nettype none
module div_asserts
	import hw_divider_pkg::*;
(
	// Watched ports
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [8:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	input wire logic       irq
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic ctlWr;
	logic ctlRd;
	assign ctlWr = regWr && regAddr == ADDR_CTRL;
	assign ctlRd = regRd && regAddr == ADDR_CTRL;
	AST_RD_IDLE: assert property (
		!$past(regRd) |-> regRdata == 8'h00) else $error("read data outside read slot");
	AST_UNMAP: assert property (
		$past(regRd && (regAddr < ADDR_DIVS_HI || regAddr > ADDR_IRQ_CLEAR)) |-> regRdata == 8'h00)
		else $error("unmapped read not zero");
	AST_DIVS_HI: assert property (
		regWr && regAddr == ADDR_DIVS_HI ##1 regRd && regAddr == ADDR_DIVS_HI
		|=> regRdata == $past(regWdata, 2)) else $error("divisor high readback");
	AST_DIVS_LO: assert property (
		regWr && regAddr == ADDR_DIVS_LO ##1 regRd && regAddr == ADDR_DIVS_LO
		|=> regRdata == $past(regWdata, 2)) else $error("divisor low readback");
	AST_CTRL_UNUSED: assert property (
		$past(ctlRd) |-> regRdata[5:1] == 5'h00) else $error("control unused bits set");
	AST_CTRL_RB: assert property (
		ctlWr ##1 ctlRd |=> regRdata[7] == $past(regWdata[7], 2)
		&& regRdata[0] == $past(regWdata[0], 2)) else $error("control readback");
	AST_START: assert property (
		ctlWr && regWdata[7] ##1 ctlRd |=> !regRdata[6]) else $error("flag not cleared at start");
	AST_IRQ_OFF: assert property (
		regWr && regAddr == ADDR_IRQ_ENABLE && regWdata[2:0] == 3'h0 |=> !irq)
		else $error("interrupt high while masked");
	COV_START: cover property (ctlWr && regWdata[7]);
	COV_IRQ: cover property ($rose(irq));
	COV_UNMAP: cover property (regRd && regAddr > ADDR_IRQ_CLEAR);
endmodule : div_asserts
bind hw_divider div_asserts u_div_asserts (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
`default_nettype wire

// File: verif/cpu_model.sv
// Partner: core-side master issuing register cycles
`timescale 1ns/100ps
`default_nettype none
module cpu_model
	import hw_divider_pkg::*;
(
	// Clock
	input  wire logic       ref_clk,
	// Register port
	output var  reg_req_t   req,
	input  wire logic [7:0] rdata
);
	// ****
	// Bus cycles
	// ****
	initial req = '0;
	// Write strobe is dropped by the next cycle issued
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		// Read data stand for the whole cycle after the strobe; take them mid-cycle
		@(negedge ref_clk);
		d = rdata;
		@(posedge ref_clk);
	endtask : rd
	task automatic wait_done(input int lim, output int n);
		logic [7:0] d;
		n = 0;
		d = 8'h00;
		while (d[CTRL_DONE_BIT] !== 1'b1 && n < lim)
		begin
			rd(ADDR_CTRL, d);
			n += 2;
		end
	endtask : wait_done
endmodule : cpu_model
`default_nettype wire

// File: verif/tb.sv
// Testbench: register-level tests of the hardware divider
`timescale 1ns/100ps
`default_nettype none
module tb
	import hw_divider_pkg::*;
;
	logic       ref_clk    = 1'b0;
	logic       rst_n      = 1'b0;
	reg_req_t   req;
	logic [7:0] regRdata;
	logic       irq;
	int         mismatches = 0;
	int         cmp_count  = 0;
	int         cyc        = 0;
	hw_divider u_hw_divider (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(req.addr),
		.regWdata(req.wdata), .regWr(req.wr), .regRd(req.rd), .regRdata(regRdata), .irq(irq));
	cpu_model u_cpu_model (.ref_clk(ref_clk), .req(req), .rdata(regRdata));
	// ****
	// Tasks
	// ****
	initial forever #25 ref_clk = ~ref_clk;
	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			mismatches++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk
	task automatic rchk(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] v;
		u_cpu_model.rd(a, v);
		chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, v});
	endtask : rchk
	task automatic do_div(input logic [31:0] e, input logic [15:0] s, input logic c);
		logic [31:0] q;
		int          n;
		int          ex;
		q = (s == 16'h0000) ? 32'hFFFFFFFF : e / s;
		ex = (s == 16'h0000) ? (c ? 4 : 2) : (c ? 128 : 64);
		u_cpu_model.wr(ADDR_IRQ_CLEAR, 8'h07);
		u_cpu_model.wr(ADDR_DIVS_HI, s[15:8]);
		rchk(ADDR_DIVS_HI, s[15:8]);
		u_cpu_model.wr(ADDR_DIVS_LO, s[7:0]);
		rchk(ADDR_DIVS_LO, s[7:0]);
		for (int i = 0; i < 4; i++)
			u_cpu_model.wr(9'(ADDR_BYTE3 + i), e[31 - 8 * i -: 8]);
		u_cpu_model.wr(ADDR_CTRL, {7'h40, c});
		rchk(ADDR_CTRL, {7'h40, c});
		u_cpu_model.wait_done(400, n);
		chk("cycles", 32'h1, {31'h0, n + 2 >= ex - 2 && n + 2 <= ex + 6});
		rchk(ADDR_CTRL, {7'h60, c});
		for (int i = 0; i < 4; i++)
			rchk(9'(ADDR_BYTE3 + i), q[31 - 8 * i -: 8]);
		rchk(ADDR_IRQ_STATUS, {5'h00, s == 16'h0000, 2'b11});
	endtask : do_div
	// ****
	// Sequence
	// ****
	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rchk(ADDR_CTRL, 8'h40);
		for (int i = 0; i < 4; i++)
			rchk(9'(ADDR_BYTE3 + i), 8'h00);
		rchk(ADDR_DIVS_HI, 8'h00);
		rchk(ADDR_DIVS_LO, 8'h00);
		chk("irq", 32'h0, {31'h0, irq});
		$display("Test reset values done");
		u_cpu_model.wr(ADDR_IRQ_ENABLE, 8'h07);
		do_div(32'hDEADBEEF, 16'h1234, 1'b0);
		do_div(32'hFFFFFFFF, 16'h0001, 1'b1);
		do_div(32'h00000007, 16'hFFFF, 1'b0);
		do_div(32'h12345678, 16'h0000, 1'b1);
		do_div(32'h89ABCDEF, 16'h0000, 1'b0);
		$display("Test divisions done");
		u_cpu_model.wr(ADDR_BYTE0, 8'h55);
		rchk(ADDR_BYTE0, 8'hFF);
		chk("irq", 32'h1, {31'h0, irq});
		u_cpu_model.wr(ADDR_IRQ_ENABLE, 8'h00);
		rchk(ADDR_IRQ_ENABLE, 8'h00);
		chk("irq", 32'h0, {31'h0, irq});
		u_cpu_model.wr(ADDR_IRQ_STATUS, 8'h00);
		u_cpu_model.wr(ADDR_IRQ_ENABLE, 8'h07);
		rchk(ADDR_IRQ_STATUS, 8'h07);
		u_cpu_model.wr(ADDR_IRQ_CLEAR, 8'h07);
		rchk(ADDR_IRQ_STATUS, 8'h00);
		chk("irq", 32'h0, {31'h0, irq});
		rchk(9'h100, 8'h00);
		rchk(9'h1FF, 8'h00);
		$display("Test interrupt and access done");
		close_out();
	end
endmodule : tb
`default_nettype wire
